// file: pdmtr_channel_trim.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
// Trim and phase stage for two microphone channels, volume on the sixth only
module pdmtr_channel_trim #(
	parameter int WIDTH   = 24,             // Sample width
	parameter int MOD_DIV = 4               // Core cycles per modulator tick
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	input  wire logic             fifth_is_mic,  // Channel fed from mic input
	input  wire logic             sixth_is_mic,
	input  wire logic [WIDTH-1:0] fifth_in,
	input  wire logic [WIDTH-1:0] sixth_in,
	output logic      [WIDTH-1:0] fifth_out,
	output logic      [WIDTH-1:0] sixth_out,
	output logic                  sixth_muted    // Sixth channel silenced
);
	import pdmtr_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [3:0] fifth_input_gain_trim_q;      // Trim codes
	logic [3:0] sixth_input_gain_trim_q;
	logic [7:0] fifth_input_phase_delay_q;    // Delay codes
	logic [7:0] sixth_input_phase_delay_q;
	logic [7:0] sixth_input_volume_q;         // Volume code
	logic [7:0] rdata_q;

	// Decodes
	wire wr_t5 = reg_wr && (reg_addr == PDMTR_CH5_GAIN_TRIM_OFS);
	wire wr_p5 = reg_wr && (reg_addr == PDMTR_CH5_PHASE_DELAY_OFS);
	wire wr_v6 = reg_wr && (reg_addr == PDMTR_CH6_VOLUME_OFS);
	wire wr_t6 = reg_wr && (reg_addr == PDMTR_CH6_GAIN_TRIM_OFS);
	wire wr_p6 = reg_wr && (reg_addr == PDMTR_CH6_PHASE_DELAY_OFS);

	// Register writes; only upper nibble of trim stored
	always_ff @(posedge core_clk) begin
		if (reset) begin
			fifth_input_gain_trim_q   <= PDMTR_TRIM_RST[7:4];
			sixth_input_gain_trim_q   <= PDMTR_TRIM_RST[7:4];
			fifth_input_phase_delay_q <= PDMTR_DELAY_RST;
			sixth_input_phase_delay_q <= PDMTR_DELAY_RST;
			sixth_input_volume_q      <= PDMTR_VOLUME_RST;
		end else begin
			if (wr_t5) fifth_input_gain_trim_q   <= reg_wdata[7:4];
			if (wr_t6) sixth_input_gain_trim_q   <= reg_wdata[7:4];
			if (wr_p5) fifth_input_phase_delay_q <= reg_wdata;
			if (wr_p6) sixth_input_phase_delay_q <= reg_wdata;
			if (wr_v6) sixth_input_volume_q      <= reg_wdata;
		end
	end

	// ****************************************
	// Read port, data one cycle after strobe
	// ****************************************
	logic [7:0] rd_mux;                       // Unmapped reads as zero
	always_comb begin
		unique case (reg_addr)
			PDMTR_CH5_GAIN_TRIM_OFS:   rd_mux = {fifth_input_gain_trim_q, 4'h0};
			PDMTR_CH5_PHASE_DELAY_OFS: rd_mux = fifth_input_phase_delay_q;
			PDMTR_CH6_VOLUME_OFS:      rd_mux = sixth_input_volume_q;
			PDMTR_CH6_GAIN_TRIM_OFS:   rd_mux = {sixth_input_gain_trim_q, 4'h0};
			PDMTR_CH6_PHASE_DELAY_OFS: rd_mux = sixth_input_phase_delay_q;
			default:                   rd_mux = 8'h00;
		endcase
	end

	// Read data held only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (reset) rdata_q <= 8'h00;
		else rdata_q <= reg_rd ? rd_mux : 8'h00;
	end
	assign reg_rdata = rdata_q;

	// ****************************************
	// Modulator clock enable divider
	// ****************************************
	logic [7:0] div_q;
	logic       mod_tick_q;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			div_q      <= 8'h00;
			mod_tick_q <= 1'b0;
		end else begin
			div_q      <= (div_q == 8'(MOD_DIV-1)) ? 8'h00 : div_q + 8'h01;
			mod_tick_q <= (div_q == 8'(MOD_DIV-1));
		end
	end

	// ****************************************
	// Gain tables, built as products of steps
	// ****************************************
	// Trim: code 8 unity, 0.1 dB per code, linear in dB
	function automatic logic [15:0] trim_gain(input logic [3:0] code);
		logic [31:0] g;
		g = {16'h0, PDMTR_GAIN_ONE};
		for (int i = 0; i < 8; i++) begin
			if (i < int'(code) - 8) g = (g * PDMTR_TRIM_STEP_UP) >> 12;
			if (i < 8 - int'(code)) g = (g * PDMTR_TRIM_STEP_DN) >> 12;
		end
		return g[15:0];
	endfunction : trim_gain

	// Volume: code 201 unity, 0.5 dB per code; Q6.12 so +27 dB fits
	// Floor of the fixed point still limits the deepest cut
	function automatic logic [17:0] vol_gain(input logic [7:0] code);
		logic [31:0] g;
		g = {16'h0, PDMTR_GAIN_ONE};
		for (int i = 0; i < 200; i++) begin
			if (i < int'(code) - 201) g = (g * PDMTR_VOL_STEP_UP) >> 12;
			if (i < 201 - int'(code)) g = (g * PDMTR_VOL_STEP_DN) >> 12;
		end
		return g[17:0];
	endfunction : vol_gain

	// ****************************************
	// Per-channel datapath
	// ****************************************
	// Trim gains and volume gain, decoded from the codes, held in separate flops
	logic [15:0] gain5_q, gain6_q;            // Trim gains, Q4.12
	logic [17:0] vol6_q;                      // Volume gain, Q6.12
	always_ff @(posedge core_clk) begin
		if (reset) begin
			gain5_q <= PDMTR_GAIN_ONE;
			gain6_q <= PDMTR_GAIN_ONE;
			vol6_q  <= {2'b00, PDMTR_GAIN_ONE};
		end else begin
			gain5_q <= trim_gain(fifth_input_gain_trim_q);
			gain6_q <= trim_gain(sixth_input_gain_trim_q);
			vol6_q  <= vol_gain(sixth_input_volume_q);
		end
	end

	wire [WIDTH-1:0] dly5, dly6;
	pdmtr_delay_line #(.WIDTH(WIDTH), .DEPTH(256)) u_dly5 (
		.core_clk (core_clk),
		.reset    (reset),
		.mod_tick (mod_tick_q),
		.delay    (fifth_is_mic ? fifth_input_phase_delay_q : 8'h00),
		.din      (fifth_in),
		.dout     (dly5)
	);
	pdmtr_delay_line #(.WIDTH(WIDTH), .DEPTH(256)) u_dly6 (
		.core_clk (core_clk),
		.reset    (reset),
		.mod_tick (mod_tick_q),
		.delay    (sixth_is_mic ? sixth_input_phase_delay_q : 8'h00),
		.din      (sixth_in),
		.dout     (dly6)
	);

	// Signed scaling, Q4.12 gains
	wire signed [WIDTH+16:0] p5 = $signed(dly5) * $signed({1'b0, gain5_q});
	wire signed [WIDTH+16:0] p6 = $signed(dly6) * $signed({1'b0, gain6_q});
	// Slice made signed again so negative samples scale correctly
	wire signed [WIDTH+33:0] q6 = $signed(p6[WIDTH+16:12]) * $signed({1'b0, vol6_q});
	wire mute6 = sixth_is_mic && (sixth_input_volume_q == PDMTR_VOLUME_MUTE);

	// Output registers; analog-fed channels bypass all settings
	always_ff @(posedge core_clk) begin
		if (reset) begin
			fifth_out   <= '0;
			sixth_out   <= '0;
			sixth_muted <= 1'b0;
		end else begin
			fifth_out   <= fifth_is_mic ? p5[WIDTH+11:12] : fifth_in;
			sixth_out   <= mute6 ? '0 :
			               (sixth_is_mic ? q6[WIDTH+11:12] : sixth_in);
			sixth_muted <= mute6;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	mute_out_a: assert property (@(posedge core_clk) disable iff (reset)
		mute6 |=> (sixth_out == '0) && sixth_muted) else $error("mute not applied");
	trim_rsvd_a: assert property (@(posedge core_clk) disable iff (reset)
		reg_rd && reg_addr == PDMTR_CH6_GAIN_TRIM_OFS |=> reg_rdata[3:0] == 4'h0)
		else $error("trim reserved bits nonzero");
	vol_store_a: assert property (@(posedge core_clk) disable iff (reset)
		wr_v6 ##1 (reg_rd && reg_addr == PDMTR_CH6_VOLUME_OFS) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("volume readback wrong");
	zero_dly_a: assert property (@(posedge core_clk) disable iff (reset)
		fifth_input_phase_delay_q == 8'h00 |-> dly5 == fifth_in) else $error("zero delay not direct");
	unity_trim_a: assert property (@(posedge core_clk) disable iff (reset)
		fifth_input_gain_trim_q == PDMTR_TRIM_UNITY |=> gain5_q == PDMTR_GAIN_ONE)
		else $error("trim 8 not unity");
	unity_vol_a: assert property (@(posedge core_clk) disable iff (reset)
		sixth_input_volume_q == PDMTR_VOLUME_UNITY |=> vol6_q == {2'b00, PDMTR_GAIN_ONE})
		else $error("volume 201 not unity");
	analog_pass_a: assert property (@(posedge core_clk) disable iff (reset)
		!fifth_is_mic |=> fifth_out == $past(fifth_in)) else $error("analog path altered");
	reset_vals_a: assert property (@(posedge core_clk)
		reset |=> sixth_input_volume_q == 8'hC9 && sixth_input_gain_trim_q == 4'h8
		          && sixth_input_phase_delay_q == 8'h00) else $error("reset value wrong");
	tick_rate_a: assert property (@(posedge core_clk) disable iff (reset)
		mod_tick_q |=> !mod_tick_q) else $error("tick too frequent");
	mute_c: cover property (@(posedge core_clk) disable iff (reset) sixth_muted);
	delay_max_c: cover property (@(posedge core_clk) disable iff (reset)
		wr_p5 && reg_wdata == 8'hFF);
	trim_low_c: cover property (@(posedge core_clk) disable iff (reset)
		fifth_input_gain_trim_q == 4'h0);

endmodule : pdmtr_channel_trim

// file: pdmtr_delay_line.sv
`timescale 1ns/1ns
// Variable sample delay in modulator clock ticks
module pdmtr_delay_line #(
	parameter int WIDTH = 24,               // Sample width
	parameter int DEPTH = 256               // Taps, covers delay 0..255
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             mod_tick,  // Modulator clock enable
	input  wire logic [7:0]       delay,     // Cycles of delay
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	import pdmtr_pkg::*;

	// ****************************************
	// Shift storage, one entry per tick
	// ****************************************
	logic [WIDTH-1:0] tap_q [DEPTH];          // tap_q[k] is input k+1 ticks ago

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_tap
			always_ff @(posedge core_clk) begin
				if (reset) begin
					tap_q[g] <= '0;
				end else if (mod_tick) begin
					tap_q[g] <= (g == 0) ? din : tap_q[(g == 0) ? 0 : g-1];
				end
			end
		end
	endgenerate

	// Zero passes the input straight through
	assign dout = (delay == 8'h00) ? din : tap_q[delay - 8'h01];

endmodule : pdmtr_delay_line

// file: pdmtr_pkg.sv
// Overview of operation
// - Gain trim scales channel; code 8 unity
// - Trim in bits 7-4; 3-0 reserved zero
// - Delay samples by code modulator cycles, max 255
// - Phase code zero adds no delay
// - Volume code zero fully mutes channel
// - Volume code 201 unity, 0.5 dB steps
// - Reset: volume C9, trim 80, delay 00
// - Settings apply only to microphone-fed channels
package pdmtr_pkg;

	// ****************************************
	// Register map, byte offsets in page zero
	// ****************************************
	localparam logic [7:0] PDMTR_CH5_GAIN_TRIM_OFS   = 8'h53; // Sits just below the fifth delay
	localparam logic [7:0] PDMTR_CH5_PHASE_DELAY_OFS = 8'h54;
	localparam logic [7:0] PDMTR_CH6_VOLUME_OFS      = 8'h57;
	localparam logic [7:0] PDMTR_CH6_GAIN_TRIM_OFS   = 8'h58;
	localparam logic [7:0] PDMTR_CH6_PHASE_DELAY_OFS = 8'h59;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] PDMTR_VOLUME_RST = 8'hC9;
	localparam logic [7:0] PDMTR_TRIM_RST   = 8'h80;
	localparam logic [7:0] PDMTR_DELAY_RST  = 8'h00;

	// ****************************************
	// Field layout and gain codes
	// ****************************************
	localparam int         PDMTR_TRIM_LSB     = 4;            // Trim field bits 7-4
	localparam logic [3:0] PDMTR_TRIM_UNITY   = 4'h8;
	localparam logic [7:0] PDMTR_VOLUME_UNITY = 8'hC9;
	localparam logic [7:0] PDMTR_VOLUME_MUTE  = 8'h00;
	// Gain in Q4.12 linear: 0.1 dB is 1.01158, 0.5 dB is 1.05925
	localparam logic [15:0] PDMTR_GAIN_ONE     = 16'h1000;
	localparam logic [15:0] PDMTR_TRIM_STEP_UP = 16'h1030;    // +0.1 dB
	localparam logic [15:0] PDMTR_TRIM_STEP_DN = 16'h0FD1;    // -0.1 dB
	localparam logic [15:0] PDMTR_VOL_STEP_UP  = 16'h10F2;    // +0.5 dB
	localparam logic [15:0] PDMTR_VOL_STEP_DN  = 16'h0F1B;    // -0.5 dB

endpackage : pdmtr_pkg

// file: tb_pdm_channel_trim_registers.sv
`timescale 1ns/1ns
// ****************************************
// Bench for the microphone trim registers
// ****************************************
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_pdm_channel_trim_registers;
	import pdmtr_pkg::*;
	localparam int MD = 4;                // Core cycles per modulator tick
	logic        core_clk, reset;         // Clock and sync reset
	logic [7:0]  reg_addr, reg_wdata;     // Register bus request
	logic        reg_wr, reg_rd;          // One-cycle strobes
	logic [7:0]  reg_rdata;               // Read answer
	logic        fifth_is_mic, sixth_is_mic;
	logic [23:0] fifth_in, sixth_in, fifth_out, sixth_out;
	logic        sixth_muted;
	int          failures, compares, cycles;
	pdmtr_channel_trim #(.WIDTH(24), .MOD_DIV(MD)) pdmtr_channel_trim_inst (
		.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .fifth_is_mic(fifth_is_mic),
		.sixth_is_mic(sixth_is_mic), .fifth_in(fifth_in), .sixth_in(sixth_in),
		.fifth_out(fifth_out), .sixth_out(sixth_out), .sixth_muted(sixth_muted));
	// Free-running 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end
	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask : wr
	// Read data is only valid in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic settle();
		repeat (6) @(posedge core_clk);
		#1;
	endtask : settle
	// ****************************************
	// Scenarios
	// ****************************************
	// Reset values, unmapped read, read data drops after one cycle
	task automatic t_reset();
		logic [7:0] d;
		rd(PDMTR_CH5_GAIN_TRIM_OFS, d);   `CHK(d, 8'h80)
		rd(PDMTR_CH5_PHASE_DELAY_OFS, d); `CHK(d, 8'h00)
		rd(PDMTR_CH6_VOLUME_OFS, d);      `CHK(d, 8'hC9)
		rd(PDMTR_CH6_GAIN_TRIM_OFS, d);   `CHK(d, 8'h80)
		rd(PDMTR_CH6_PHASE_DELAY_OFS, d); `CHK(d, 8'h00)
		@(posedge core_clk);
		#1 `CHK(reg_rdata, 8'h00)
		rd(8'h55, d);                     `CHK(d, 8'h00)
	endtask : t_reset
	// Write all ones and patterns; reserved trim bits stay zero
	task automatic t_regs();
		logic [7:0] d;
		wr(PDMTR_CH6_GAIN_TRIM_OFS, 8'hFF);
		rd(PDMTR_CH6_GAIN_TRIM_OFS, d);   `CHK(d, 8'hF0)
		wr(PDMTR_CH5_GAIN_TRIM_OFS, 8'h0F);
		rd(PDMTR_CH5_GAIN_TRIM_OFS, d);   `CHK(d, 8'h00)
		wr(PDMTR_CH6_PHASE_DELAY_OFS, 8'hA5);
		rd(PDMTR_CH6_PHASE_DELAY_OFS, d); `CHK(d, 8'hA5)
		wr(PDMTR_CH6_VOLUME_OFS, 8'h3C);
		rd(PDMTR_CH6_VOLUME_OFS, d);      `CHK(d, 8'h3C)
		// Write then read with no gap between the strobes
		@(posedge core_clk);
		reg_addr  <= PDMTR_CH6_VOLUME_OFS;
		reg_wdata <= 8'h5A;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		reg_rd    <= 1'b1;
		@(posedge core_clk);
		reg_rd    <= 1'b0;
		#1 `CHK(reg_rdata, 8'h5A)
		wr(8'h55, 8'h77);
		rd(8'h55, d);                     `CHK(d, 8'h00)
		// Trims back to unity and sixth delay to zero for the datapath tests; volume left at 5A
		wr(PDMTR_CH6_GAIN_TRIM_OFS, 8'h80);
		wr(PDMTR_CH5_GAIN_TRIM_OFS, 8'h80);
		wr(PDMTR_CH6_PHASE_DELAY_OFS, 8'h00);
	endtask : t_regs
	// Gain of the sixth channel, loose bounds allow fixed-point rounding
	task automatic t_gain(input logic [7:0] v, input logic [7:0] t,
			input logic [23:0] lo, input logic [23:0] hi);
		@(posedge core_clk);
		sixth_is_mic <= 1'b1;
		sixth_in     <= 24'h010000;
		wr(PDMTR_CH6_VOLUME_OFS, v);
		wr(PDMTR_CH6_GAIN_TRIM_OFS, t);
		settle();
		`CHK((sixth_out >= lo) && (sixth_out <= hi), 1'b1)
	endtask : t_gain
	// Mute only on microphone-fed channel; analog path bypasses settings
	task automatic t_mute();
		wr(PDMTR_CH6_VOLUME_OFS, 8'h00);
		settle();
		`CHK(sixth_muted, 1'b1)
		`CHK(sixth_out, 24'h000000)
		@(posedge core_clk);
		sixth_is_mic <= 1'b0;
		settle();
		`CHK(sixth_muted, 1'b0)
		`CHK(sixth_out, 24'h010000)
		wr(PDMTR_CH6_VOLUME_OFS, 8'hC9);
	endtask : t_mute
	// Step latency through the fifth channel for delay code n
	task automatic t_delay(input logic [7:0] n, input logic mic);
		int lat;
		@(posedge core_clk);
		fifth_is_mic <= mic;
		fifth_in     <= 24'h000111;
		wr(PDMTR_CH5_PHASE_DELAY_OFS, n);
		repeat (n * MD + 10) @(posedge core_clk);
		fifth_in <= 24'h000222;
		lat = 0;
		while (fifth_out !== 24'h000222 && lat < 1200) begin
			@(posedge core_clk);
			#1 lat++;
		end
		if (mic && n != 0)
			`CHK((lat > (n - 1) * MD + 1) && (lat <= n * MD + 1), 1'b1)
		else
			`CHK(lat, 1)
	endtask : t_delay
	// Verdict and end of run
	task automatic summarize();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		failures = 0; compares = 0; cycles = 0;
		reset = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00;
		reg_wr = 1'b0; reg_rd = 1'b0; fifth_is_mic = 1'b1; sixth_is_mic = 1'b1;
		fifth_in = 24'h000000; sixth_in = 24'h000000;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		t_regs();
		t_gain(8'hC9, 8'h80, 24'h010000, 24'h010000);
		t_gain(8'hC9, 8'h90, 24'h0102C0, 24'h010340);
		t_gain(8'hC9, 8'h00, 24'h00E800, 24'h00EB00);
		t_gain(8'hC9, 8'hF0, 24'h011400, 24'h011700);
		t_gain(8'hCB, 8'h80, 24'h011D00, 24'h012100);
		t_gain(8'hDD, 8'h80, 24'h031800, 24'h033800);
		t_gain(8'h01, 8'h80, 24'h000000, 24'h000001);
		t_gain(8'hFF, 8'h80, 24'h158000, 24'h168000);
		wr(PDMTR_CH6_VOLUME_OFS, 8'hC9);
		t_mute();
		t_delay(8'h01, 1'b1);
		t_delay(8'h02, 1'b1);
		t_delay(8'hFF, 1'b1);
		t_delay(8'h00, 1'b1);
		t_delay(8'hFF, 1'b0);
		summarize();
	end
endmodule : tb_pdm_channel_trim_registers
